// file: src/srsc_pkg.sv
/*
 * srsc_pkg: opcodes, timing figures and parameter-header layout of the
 * suspend / resume / reset / parameter-table command logic.
 * Assumes a 10 MHz core clock and a byte-serial link, most significant
 * bit first.
 */
package srsc_pkg;

    // ==========================================================
    // opcodes
    // ==========================================================
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_DUAL_READ = 8'h3B;
    localparam logic [7:0] OP_QUAD_READ = 8'h6B;
    localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;
    localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
    localparam logic [7:0] OP_PARAM_TABLE_READ = 8'h5A;
    localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_WRITE_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_READ_SECURITY = 8'h2B;
    localparam logic [7:0] OP_READ_ID = 8'h9F;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_READ_SIGNATURE = 8'hAB;
    localparam logic [7:0] OP_READ_MFR_ID = 8'h90;
    localparam logic [7:0] OP_ALLOW_B1 = 8'hB1;
    localparam logic [7:0] OP_ALLOW_C1 = 8'hC1;
    localparam logic [7:0] OP_SUSPEND = 8'hB0;
    localparam logic [7:0] OP_RESUME = 8'h30;
    localparam logic [7:0] OP_RESET_ARM = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;
    localparam logic [7:0] OP_NULL = 8'h00;
    localparam logic [7:0] OP_READ_CONFIG = 8'h15;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int CLK_KHZ = 10000;
    localparam int ERASE_MIN_US = 20;
    // least time: round up to whole cycles
    localparam int ERASE_MIN_CYC = (ERASE_MIN_US * CLK_KHZ + 999) / 1000;
    localparam int ERASE_CNT_W = 8;

    // ==========================================================
    // frame layout of the parameter-table read
    // ==========================================================
    localparam logic [2:0] BYTE_ADDR_FIRST = 3'h1;
    localparam logic [2:0] BYTE_ADDR_LAST = 3'h3;
    localparam logic [2:0] BYTE_DATA = 3'h5;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // ==========================================================
    // parameter-table header
    // ==========================================================
    localparam logic [31:0] HDR_SIGNATURE = 32'h50444653;
    localparam logic [7:0] HDR_MINOR_REV = 8'h06;
    localparam logic [7:0] HDR_MAJOR_REV = 8'h01;
    localparam logic [7:0] HDR_COUNT = 8'h03;
    localparam logic [7:0] HDR_UNUSED = 8'hFF;
    localparam logic [7:0] HDR_PARAM_ID = 8'h00;
    localparam logic [7:0] HDR_PARAM_LEN = 8'h10;
    localparam logic [23:0] HDR_PTR_DEFAULT = 24'h000030;

    // read-type, write-latch, suspend, resume and reset commands still taken while suspended
    function automatic logic srsc_allowed(input logic [7:0] op);
        case (op)
            OP_READ, OP_FAST_READ, OP_DUAL_READ, OP_QUAD_READ,
            OP_DUAL_IO_READ, OP_QUAD_IO_READ, OP_PARAM_TABLE_READ,
            OP_WRITE_LATCH_SET, OP_WRITE_LATCH_CLEAR, OP_READ_SECURITY,
            OP_READ_ID, OP_READ_STATUS, OP_READ_SIGNATURE, OP_READ_MFR_ID,
            OP_ALLOW_B1, OP_ALLOW_C1, OP_SUSPEND, OP_RESUME, OP_RESET_ARM,
            OP_RESET, OP_NULL, OP_READ_CONFIG: srsc_allowed = 1'b1;
            default: srsc_allowed = 1'b0;
        endcase
    endfunction : srsc_allowed

endpackage : srsc_pkg

// file: src/srsc_sync.sv
/*
 * srsc_sync: two-stage synchroniser, one per bit of a bus of levels.
 * Assumes each bit is a slow level; no bus coherence is given.
 */
`timescale 1ns/1ps
module srsc_sync
    import srsc_pkg::*;
#(
    parameter int WIDTH = 3
)
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge core_clk_in)
    begin
        meta_q <= async_in;
        sync_out <= meta_q;
    end
endmodule : srsc_sync

// file: src/srsc_header_rom.sv
/*
 * srsc_header_rom: first sixteen bytes of the parameter table.
 * Assumes the byte address comes from the link; bytes past the header
 * read as FFh because the full tables are kept elsewhere.
 */
`timescale 1ns/1ps
module srsc_header_rom
    import srsc_pkg::*;
#(
    parameter logic [23:0] TABLE_PTR = HDR_PTR_DEFAULT
)
(
    input wire logic [23:0] addr_in,
    output logic [7:0] data_out
);
    always_comb
    begin
        data_out = HDR_UNUSED;
        if (addr_in[23:4] == 20'h00000)
        begin
            case (addr_in[3:0])
                4'h0: data_out = HDR_SIGNATURE[7:0];
                4'h1: data_out = HDR_SIGNATURE[15:8];
                4'h2: data_out = HDR_SIGNATURE[23:16];
                4'h3: data_out = HDR_SIGNATURE[31:24];
                4'h4: data_out = HDR_MINOR_REV;
                4'h5: data_out = HDR_MAJOR_REV;
                4'h6: data_out = HDR_COUNT;
                4'h8: data_out = HDR_PARAM_ID;
                4'h9: data_out = HDR_MINOR_REV;
                4'hA: data_out = HDR_MAJOR_REV;
                4'hB: data_out = HDR_PARAM_LEN;
                4'hC: data_out = TABLE_PTR[7:0];
                4'hD: data_out = TABLE_PTR[15:8];
                4'hE: data_out = TABLE_PTR[23:16];
                default: data_out = HDR_UNUSED;
            endcase
        end
    end
endmodule : srsc_header_rom

// file: src/srsc_ctrl.sv
/*
 * srsc_ctrl: serial command front end for suspend, resume, software
 * reset and the parameter-table header read of a serial flash.
 * Assumes the array engine reports its busy levels on the core clock
 * and pauses while engine_hold_out is high; pins are asynchronous.
 */
`timescale 1ns/1ps
module srsc_ctrl
    import srsc_pkg::*;
#(
    parameter logic [23:0] TABLE_PTR = HDR_PTR_DEFAULT
)
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic si_in,
    input wire logic erase_busy_in,
    input wire logic program_busy_in,
    input wire logic perf_mode_in,
    input wire logic [23:0] op_addr_in,
    output logic so_out,
    output logic so_oe_out,
    output logic write_enable_latch_out,
    output logic erase_suspended_flag_out,
    output logic program_suspended_flag_out,
    output logic [7:0] security_status_out,
    output logic busy_out,
    output logic engine_hold_out,
    output logic resume_out,
    output logic abort_out,
    output logic [23:0] suspended_addr_out,
    output logic [7:0] cmd_out,
    output logic cmd_valid_out
);
    // ==========================================================
    // pin synchronisation and edge detection
    // ==========================================================
    logic cs_n_s, sclk_s, si_s;
    logic sclk_prev_q, cs_prev_q;

    srsc_sync #(.WIDTH(3)) u_sync (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .async_in({cs_n_in, sclk_in, si_in}),
        .sync_out({cs_n_s, sclk_s, si_s})
    );

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            sclk_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end
        else
        begin
            sclk_prev_q <= sclk_s;
            cs_prev_q <= cs_n_s;
        end
    end

    wire selected = ~cs_n_s;
    wire sclk_rise = selected & sclk_s & ~sclk_prev_q;
    wire sclk_fall = selected & ~sclk_s & sclk_prev_q;
    wire frame_end = cs_n_s & ~cs_prev_q;

    // ==========================================================
    // byte framing
    // ==========================================================
    logic [7:0] shift_q, opcode_q;
    logic [2:0] bit_q, byte_q;
    logic [23:0] addr_q;
    logic [7:0] rom_data;

    wire [7:0] shift_d = {shift_q[6:0], si_s};
    wire byte_done = sclk_rise & (bit_q == BIT_LAST);
    wire is_table_read = (opcode_q == OP_PARAM_TABLE_READ);
    wire data_phase = is_table_read & (byte_q == BYTE_DATA);
    wire addr_phase = (byte_q >= BYTE_ADDR_FIRST) &
                      (byte_q <= BYTE_ADDR_LAST);

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in | ~selected)
        begin
            bit_q <= 3'h0;
            byte_q <= 3'h0;
            shift_q <= 8'h00;
        end
        else if (sclk_rise)
        begin
            shift_q <= shift_d;
            bit_q <= bit_q + 3'h1;
            if (byte_done && byte_q != BYTE_DATA)
                byte_q <= byte_q + 3'h1;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            opcode_q <= OP_NULL;
            addr_q <= 24'h000000;
        end
        else if (byte_done)
        begin
            if (byte_q == 3'h0)
                opcode_q <= shift_d;
            else if (addr_phase)
                addr_q <= {addr_q[15:0], shift_d};
            else if (data_phase)
                addr_q <= addr_q + 24'h000001;
        end
    end

    srsc_header_rom #(.TABLE_PTR(TABLE_PTR)) u_rom (
        .addr_in(addr_q),
        .data_out(rom_data)
    );

    // data leaves on the falling clock so the host samples it on the rise
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in | ~selected)
        begin
            so_out <= 1'b0;
            so_oe_out <= 1'b0;
        end
        else if (sclk_fall & data_phase)
        begin
            so_out <= rom_data[3'h7 - bit_q];
            so_oe_out <= 1'b1;
        end
    end

    // ==========================================================
    // command decode at deselect
    // ==========================================================
    logic erase_susp_q, prog_susp_q, pend_q, arm_q, latch_q;
    logic [ERASE_CNT_W-1:0] erase_cnt_q;

    wire suspended = erase_susp_q | prog_susp_q;
    // commands outside the list are dropped while suspended
    wire allowed = ~suspended | srsc_allowed(opcode_q);
    wire any_cmd = frame_end & (byte_q != 3'h0);
    // single-byte commands count only on a whole-byte deselect
    wire exec = frame_end & (byte_q == 3'h1) & (bit_q == 3'h0) & allowed;
    wire do_latch_set = exec & (opcode_q == OP_WRITE_LATCH_SET);
    wire do_latch_clr = exec & (opcode_q == OP_WRITE_LATCH_CLEAR);
    wire do_arm = exec & (opcode_q == OP_RESET_ARM);
    wire do_reset = exec & (opcode_q == OP_RESET) & arm_q;
    wire resume_ok = suspended & ~perf_mode_in;
    wire do_resume = exec & (opcode_q == OP_RESUME) & resume_ok;
    wire do_susp = exec & (opcode_q == OP_SUSPEND) & ~suspended;
    wire erase_ready = (erase_cnt_q >= ERASE_CNT_W'(ERASE_MIN_CYC));
    wire erase_run = erase_busy_in & ~suspended & ~pend_q;
    wire prog_run = program_busy_in & ~suspended;
    wire want_erase_susp = (do_susp & erase_run) | pend_q;
    wire enter_erase = want_erase_susp & erase_ready;
    wire enter_prog = do_susp & prog_run & ~erase_busy_in;
    wire enter_any = enter_erase | enter_prog;

    // reset arming: any other completed command disarms
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in | do_reset)
            arm_q <= 1'b0;
        else if (do_arm)
            arm_q <= 1'b1;
        else if (any_cmd)
            arm_q <= 1'b0;
    end

    // erase time already run, so a suspend can wait out the minimum
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in | do_reset | ~erase_busy_in)
            erase_cnt_q <= '0;
        else if (~suspended & ~erase_ready)
            erase_cnt_q <= erase_cnt_q + ERASE_CNT_W'(1);
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in | do_reset)
        begin
            erase_susp_q <= 1'b0;
            prog_susp_q <= 1'b0;
            pend_q <= 1'b0;
            latch_q <= 1'b0;
        end
        else
        begin
            pend_q <= want_erase_susp & ~erase_ready & erase_busy_in;
            if (enter_erase)
                erase_susp_q <= 1'b1;
            else if (do_resume)
                erase_susp_q <= 1'b0;
            if (enter_prog)
                prog_susp_q <= 1'b1;
            else if (do_resume)
                prog_susp_q <= 1'b0;
            // suspend entry wins over a latch set in the same cycle
            if (enter_any)
                latch_q <= 1'b0;
            else if (do_latch_set)
                latch_q <= 1'b1;
            else if (do_latch_clr)
                latch_q <= 1'b0;
        end
    end

    // ==========================================================
    // outputs to the array engine and status
    // ==========================================================
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            write_enable_latch_out <= 1'b0;
            erase_suspended_flag_out <= 1'b0;
            program_suspended_flag_out <= 1'b0;
            security_status_out <= 8'h00;
            busy_out <= 1'b0;
            engine_hold_out <= 1'b0;
            resume_out <= 1'b0;
            abort_out <= 1'b0;
            suspended_addr_out <= 24'h000000;
            cmd_out <= OP_NULL;
            cmd_valid_out <= 1'b0;
        end
        else
        begin
            write_enable_latch_out <= latch_q;
            erase_suspended_flag_out <= erase_susp_q;
            program_suspended_flag_out <= prog_susp_q;
            security_status_out <= {4'h0, erase_susp_q, prog_susp_q,
                                    2'b00};
            // busy holds through the resumed write
            busy_out <= (erase_busy_in | program_busy_in) &
                        ~suspended & ~do_reset;
            engine_hold_out <= suspended;
            resume_out <= do_resume;
            abort_out <= do_reset & (erase_busy_in | program_busy_in);
            // the array read path blanks this region while suspended
            if (enter_any)
                suspended_addr_out <= op_addr_in;
            cmd_out <= opcode_q;
            cmd_valid_out <= any_cmd & allowed;
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    erase_flag_set_a: assert property (@(posedge core_clk_in)
        disable iff (reset_in) enter_erase |=> ##1
        (erase_suspended_flag_out && security_status_out[3]))
        else $error("erase suspend flag not reported");

    prog_flag_set_a: assert property (@(posedge core_clk_in)
        disable iff (reset_in) enter_prog |=> ##1
        (program_suspended_flag_out && security_status_out[2]))
        else $error("program suspend flag not reported");

    resume_clears_a: assert property (@(posedge core_clk_in)
        disable iff (reset_in) do_resume |=> ##1
        (!erase_suspended_flag_out && !program_suspended_flag_out))
        else $error("resume left a suspend flag set");

    suspend_latch_a: assert property (@(posedge core_clk_in)
        disable iff (reset_in) enter_any |=> ##1
        !write_enable_latch_out)
        else $error("write latch not cleared on suspend");

    erase_delay_a: assert property (@(posedge core_clk_in)
        disable iff (reset_in) $rose(erase_susp_q) |->
        $past(erase_cnt_q) >= ERASE_CNT_W'(ERASE_MIN_CYC))
        else $error("erase suspended before minimum erase time");

    perf_block_a: assert property (@(posedge core_clk_in)
        disable iff (reset_in) (exec && opcode_q == OP_RESUME &&
        perf_mode_in && suspended) |=> suspended)
        else $error("resume taken in performance enhance mode");

    reset_arm_a: assert property (@(posedge core_clk_in)
        disable iff (reset_in) (any_cmd && !do_arm) |=> !arm_q)
        else $error("reset arm survived another command");

    soft_reset_a: assert property (@(posedge core_clk_in)
        disable iff (reset_in) do_reset |=> ##1 (!write_enable_latch_out
        && !erase_suspended_flag_out && !program_suspended_flag_out))
        else $error("software reset left volatile state");

    idle_suspend_a: assert property (@(posedge core_clk_in)
        disable iff (reset_in) (do_susp && !erase_busy_in &&
        !program_busy_in) |=> !suspended && !pend_q)
        else $error("suspend taken with nothing running");

    sig_byte_a: assert property (@(posedge core_clk_in)
        disable iff (reset_in) (addr_q == 24'h000000) |->
        rom_data == 8'h53)
        else $error("header byte 0 is not the signature low byte");

endmodule : srsc_ctrl

// file: tb/srsc_host_model.sv
/*
 * srsc_host_model: host side of the serial link, mode 0, MSB first.
 * Assumes the bench calls frame() and then leaves cs high long enough
 * for the device to finish the frame; sclk stands still between frames.
 */
`timescale 1ns/1ps
module srsc_host_model
(
    output logic cs_n_out,
    output logic sclk_out,
    output logic si_out,
    input wire logic so_in,
    input wire logic so_oe_in
);
    // ==========================================================
    // frame driver
    // ==========================================================
    logic [7:0] rx [0:15];
    logic oe_all;

    initial
    begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        si_out = 1'b0;
        oe_all = 1'b0;
    end

    // tx is left aligned: only its top n_tx bytes are sent
    task automatic frame(input logic [39:0] tx, input int n_tx,
                         input int n_rd);
        int i;
        // offset keeps link edges off the core clock edges
        #37;
        cs_n_out <= 1'b0;
        oe_all = 1'b1;
        #400;
        for (i = 0; i < 8 * (n_tx + n_rd); i++)
        begin
            if (i < 8 * n_tx)
                si_out <= tx[39 - i];
            else
                si_out <= ~si_out;
            #400;
            sclk_out <= 1'b1;
            if (i >= 8 * n_tx)
            begin
                rx[(i / 8) - n_tx][7 - (i % 8)] = so_in;
                oe_all = oe_all & so_oe_in;
            end
            #400;
            sclk_out <= 1'b0;
        end
        #400;
        cs_n_out <= 1'b1;
        // a released line must not keep its last value
        si_out <= ~si_out;
    endtask : frame
endmodule : srsc_host_model

// file: tb/tb.sv
/*
 * tb: directed bench of srsc_ctrl through the serial link.
 * Assumes the host model in srsc_host_model and a 10 MHz core clock.
 */
`timescale 1ns/1ps
module tb
    import srsc_pkg::*;
;
    // ==========================================================
    // signals and instances
    // ==========================================================
    localparam logic [23:0] TBL_PTR = 24'h123456;
    localparam int RECOVERY_CYC = 200;
    logic core_clk_in = 1'b0;
    logic reset_in, erase_busy_in, program_busy_in, perf_mode_in;
    logic [23:0] op_addr_in;
    wire cs_n, sclk, si, so, so_oe, wlatch, esusp, psusp, busy, hold;
    wire resume_p, abort_p, cmd_valid;
    wire [7:0] sec, cmd;
    wire [23:0] susp_addr;
    wire [127:0] hdr_exp;
    int n_errors = 0;
    int n_checks = 0;
    int n_valid = 0;
    int n_resume = 0;
    int n_abort = 0;
    int v;

    assign hdr_exp = {HDR_UNUSED, TBL_PTR, HDR_PARAM_LEN, HDR_MAJOR_REV,
        HDR_MINOR_REV, HDR_PARAM_ID, HDR_UNUSED, HDR_COUNT, HDR_MAJOR_REV,
        HDR_MINOR_REV, HDR_SIGNATURE};

    always #50 core_clk_in = ~core_clk_in;

    srsc_host_model host (.cs_n_out(cs_n), .sclk_out(sclk), .si_out(si),
        .so_in(so), .so_oe_in(so_oe));

    srsc_ctrl #(.TABLE_PTR(TBL_PTR)) dut (.core_clk_in(core_clk_in),
        .reset_in(reset_in), .cs_n_in(cs_n), .sclk_in(sclk), .si_in(si),
        .erase_busy_in(erase_busy_in), .program_busy_in(program_busy_in),
        .perf_mode_in(perf_mode_in), .op_addr_in(op_addr_in),
        .so_out(so), .so_oe_out(so_oe), .write_enable_latch_out(wlatch),
        .erase_suspended_flag_out(esusp),
        .program_suspended_flag_out(psusp), .security_status_out(sec),
        .busy_out(busy), .engine_hold_out(hold), .resume_out(resume_p),
        .abort_out(abort_p), .suspended_addr_out(susp_addr),
        .cmd_out(cmd), .cmd_valid_out(cmd_valid));

    // pulses last one cycle, so they are counted where they stand
    always @(posedge core_clk_in)
    begin
        if (cmd_valid === 1'b1) n_valid++;
        if (resume_p === 1'b1) n_resume++;
        if (abort_p === 1'b1) n_abort++;
    end

    // ==========================================================
    // tasks
    // ==========================================================
    task automatic check(input string name, input logic [23:0] seen,
                         input logic [23:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    task automatic op(input logic [7:0] code);
        host.frame({code, 32'h0}, 1, 0);
        repeat (10) @(posedge core_clk_in);
    endtask : op

    task automatic table_read(input logic [7:0] a, input int n);
        int i;
        int b;
        host.frame({OP_PARAM_TABLE_READ, 16'h0, a, 8'h0}, 5, n);
        repeat (10) @(posedge core_clk_in);
        check("oe_seen", 24'(host.oe_all), 24'h1);
        check("oe_after", 24'(so_oe), 24'h0);
        for (i = 0; i < n; i++)
        begin
            b = a + i;
            check("tbl", 24'(host.rx[i]),
                24'(b < 16 ? hdr_exp[8 * b +: 8] : 8'hFF));
        end
    endtask : table_read

    // ==========================================================
    // tests
    // ==========================================================
    initial
    begin
        reset_in = 1'b1;
        erase_busy_in = 1'b0;
        program_busy_in = 1'b0;
        perf_mode_in = 1'b0;
        op_addr_in = 24'h0;
        repeat (4) @(posedge core_clk_in);
        reset_in <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        check("latch", 24'(wlatch), 24'h0);
        check("flags", 24'({esusp, psusp, busy, hold}), 24'h0);
        check("cmd", 24'({sec, cmd}), 24'h0);
        $display("test reset_values done");

        op(OP_SUSPEND);
        check("idle_susp", 24'({esusp, psusp, hold}), 24'h0);
        $display("test idle_suspend done");

        program_busy_in <= 1'b1;
        op(OP_WRITE_LATCH_SET);
        check("latch", 24'(wlatch), 24'h1);
        op(OP_RESET_ARM);
        op(OP_NULL);
        op(OP_RESET);
        check("no_reset", 24'(wlatch), 24'h1);
        check("no_abort", 24'(n_abort), 24'h0);
        op(OP_RESET_ARM);
        op(OP_RESET);
        check("reset_latch", 24'(wlatch), 24'h0);
        check("abort", 24'(n_abort), 24'h1);
        program_busy_in <= 1'b0;
        repeat (RECOVERY_CYC) @(posedge core_clk_in);
        $display("test software_reset done");

        program_busy_in <= 1'b1;
        op_addr_in <= 24'h0A1230;
        op(OP_WRITE_LATCH_SET);
        op(OP_SUSPEND);
        check("psusp", 24'({esusp, psusp, wlatch}), 24'h2);
        check("sec", 24'(sec), 24'h04);
        check("busy_hold", 24'({busy, hold}), 24'h1);
        check("p_addr", susp_addr, 24'h0A1230);
        v = n_valid;
        op(8'h02);
        check("dropped", 24'(n_valid - v), 24'h0);
        op(OP_WRITE_LATCH_SET);
        check("latch_set", 24'(wlatch), 24'h1);
        check("cmd_op", 24'(cmd), 24'(OP_WRITE_LATCH_SET));
        op(OP_WRITE_LATCH_CLEAR);
        check("latch_clr", 24'(wlatch), 24'h0);
        perf_mode_in <= 1'b1;
        op(OP_RESUME);
        check("perf_res", 24'({psusp, n_resume[3:0]}), 24'h10);
        perf_mode_in <= 1'b0;
        op(OP_RESUME);
        check("resumed", 24'({psusp, n_resume[3:0]}), 24'h01);
        check("busy_res", 24'({busy, hold}), 24'h2);
        program_busy_in <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        check("busy_end", 24'(busy), 24'h0);
        repeat (10000) @(posedge core_clk_in);
        $display("test program_suspend done");

        op_addr_in <= 24'h03F000;
        op(OP_WRITE_LATCH_SET);
        check("e_latch", 24'(wlatch), 24'h1);
        erase_busy_in <= 1'b1;
        op(OP_SUSPEND);
        check("early", 24'(esusp), 24'h0);
        repeat (130) @(posedge core_clk_in);
        check("esusp", 24'({esusp, psusp, wlatch, hold}), 24'h9);
        check("sec", 24'(sec), 24'h08);
        check("e_addr", susp_addr, 24'h03F000);
        v = n_valid;
        op(8'h20);
        check("dropped", 24'(n_valid - v), 24'h0);
        op(OP_RESUME);
        check("resumed", 24'({esusp, n_resume[3:0]}), 24'h02);
        erase_busy_in <= 1'b0;
        $display("test erase_suspend done");

        table_read(8'h00, 16);
        table_read(8'h0E, 3);
        $display("test param_table done");
        end_sim();
    end

    initial
    begin
        #3000000;
        n_errors++;
        $display("watchdog expired");
        end_sim();
    end
endmodule : tb
